// *** core/usbsh_top.sv ***
// Control endpoint setup handshake with hazard guard and recovery
//
// Behaviour
// - SETUP token sets setup_pending_flag and raises the USB interrupt.
// - While setup_pending_flag is set, an IN token is NAKed if the IN endpoint is enabled and no transmission is active.
// - Flag clear during second CRC bit must never cause endless sending.
// - The hazard window is the second CRC bit plus an 83 ns guard rounded up to 5 cycles; clears there defer.
// - Clearing module enable clears the setup flag, pending clear and IN length, and ends transmission.
// - Writing zero to usb_power_control disables regulators, clears error; a fault set in the same cycle wins.
// - Read-only bus_power_pin_valid_flag shows a valid bus_power_pin supply.
// - With endpoint_zero_enable off, flag clear leaves token state alone.
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "usbsh_regs.svh"
module usbsh_top
  import usbsh_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Token decoder, same clock
  input wire logic TOK_SETUP,
  input wire logic TOK_IN,
  input wire logic TOK_IN_CRC2,
  input wire logic TX_BYTE_SENT,
  // Pins from outside
  input wire logic BUS_POWER_PIN,
  input wire logic DET_FAULT_PIN,
  // Link and power outputs
  output logic TX_NAK,
  output logic TX_ACTIVE,
  output logic USB_IRQ,
  output logic USB_REGULATOR_OUTPUT
);
  localparam logic [2:0] HAZ_CYC = 3'(`USBSH_HAZ_CYC);

  usbsh_state_t s_r;
  usbsh_state_t s_nxt;
  logic wr_acc;
  logic rd_acc;
  logic ep_on;
  logic clr_req;
  logic in_hazard;

  always_comb begin
    wr_acc = AVS_WRITE && !s_r.wait_n;
    rd_acc = AVS_READ && !s_r.wait_n;
    ep_on = s_r.epi_en || s_r.epo_en;
    clr_req = wr_acc && (AVS_ADDRESS == `USBSH_FLAG_OFS)
      && AVS_WRITEDATA[`USBSH_FLAG_SETUP];
    in_hazard = TOK_IN_CRC2 || (s_r.guard != 3'h0);
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.nak = 1'b0;
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    s_nxt.vs1 = BUS_POWER_PIN;
    s_nxt.vs2 = s_r.vs1;
    s_nxt.vs3 = s_r.vs2;
    if (s_r.vs2 == s_r.vs3) begin
      s_nxt.bus_power_pin_lvl = s_r.vs3;
    end
    s_nxt.bf1 = DET_FAULT_PIN;
    s_nxt.bf2 = s_r.bf1;
    s_nxt.bf3 = s_r.bf2;
    if (s_r.bf2 == s_r.bf3) begin
      s_nxt.bf_lvl = s_r.bf3;
    end
    // ------------------------------------------------------------
    // Hazard window guard
    // ------------------------------------------------------------
    if (TOK_IN_CRC2) begin
      s_nxt.guard = HAZ_CYC;
    end else if (s_r.guard != 3'h0) begin
      s_nxt.guard = s_r.guard - 3'h1;
    end
    // ------------------------------------------------------------
    // Setup pending flag
    // ------------------------------------------------------------
    if (clr_req) begin
      if (ep_on && in_hazard) begin
        s_nxt.clr_pend = 1'b1;
      end else begin
        s_nxt.flag = 1'b0;
      end
    end else if (s_r.clr_pend && !in_hazard) begin
      s_nxt.flag = 1'b0;
      s_nxt.clr_pend = 1'b0;
    end
    if (TOK_SETUP && s_r.mod_en && ep_on) begin
      s_nxt.flag = 1'b1;
      s_nxt.clr_pend = 1'b0;
    end
    // ------------------------------------------------------------
    // IN token answer and bounded transmission
    // ------------------------------------------------------------
    if (TOK_IN && s_r.mod_en && s_r.epi_en && !s_r.tx_act) begin
      if (s_r.flag || s_r.in_len == 8'h00) begin
        s_nxt.nak = 1'b1;
      end else begin
        s_nxt.tx_act = 1'b1;
        s_nxt.tx_cnt = s_r.in_len;
        s_nxt.in_len = 8'h00;
      end
    end
    if (s_r.tx_act && TX_BYTE_SENT) begin
      s_nxt.tx_cnt = s_r.tx_cnt - 8'h01;
      if (s_r.tx_cnt == 8'h01) begin
        s_nxt.tx_act = 1'b0;
      end
    end
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    s_nxt.wait_n = !((AVS_READ || AVS_WRITE) && s_r.wait_n);
    if (wr_acc) begin
      if (AVS_ADDRESS == `USBSH_CTRL_OFS) begin
        s_nxt.mod_en = AVS_WRITEDATA[`USBSH_CTRL_MOD_EN];
        s_nxt.epi_en = AVS_WRITEDATA[`USBSH_CTRL_EPI_EN];
        s_nxt.epo_en = AVS_WRITEDATA[`USBSH_CTRL_EPO_EN];
      end else if (AVS_ADDRESS == `USBSH_PWR_OFS) begin
        s_nxt.pwr = AVS_WRITEDATA[7:0];
        if (AVS_WRITEDATA[7:0] == 8'h00) begin
          s_nxt.det_err = 1'b0;
        end
      end else if (AVS_ADDRESS == `USBSH_INLEN_OFS) begin
        s_nxt.in_len = AVS_WRITEDATA[7:0];
      end
    end
    // Fault set wins over a clearing write
    if (s_r.bf_lvl && (s_r.pwr != 8'h00)) begin
      s_nxt.det_err = 1'b1;
    end
    s_nxt.rdata = 32'h0000_0000;
    if (s_r.wait_n && AVS_READ) begin
      if (AVS_ADDRESS == `USBSH_CTRL_OFS) begin
        s_nxt.rdata[`USBSH_CTRL_MOD_EN] = s_r.mod_en;
        s_nxt.rdata[`USBSH_CTRL_EPI_EN] = s_r.epi_en;
        s_nxt.rdata[`USBSH_CTRL_EPO_EN] = s_r.epo_en;
      end else if (AVS_ADDRESS == `USBSH_FLAG_OFS) begin
        s_nxt.rdata[`USBSH_FLAG_SETUP] = s_r.flag;
        s_nxt.rdata[`USBSH_FLAG_BUS_POWER_PIN] = s_r.bus_power_pin_lvl
          && s_r.pwr[`USBSH_PWR_DET_EN] && !s_r.det_err;
        s_nxt.rdata[`USBSH_FLAG_DETERR] = s_r.det_err;
        s_nxt.rdata[`USBSH_FLAG_TXACT] = s_r.tx_act;
      end else if (AVS_ADDRESS == `USBSH_PWR_OFS) begin
        s_nxt.rdata[7:0] = s_r.pwr;
      end else if (AVS_ADDRESS == `USBSH_INLEN_OFS) begin
        s_nxt.rdata[7:0] = s_r.in_len;
      end
    end
    // ------------------------------------------------------------
    // Module disable returns the setup flag, IN length and transmission state to idle
    // ------------------------------------------------------------
    if (!s_nxt.mod_en) begin
      s_nxt.flag = 1'b0;
      s_nxt.clr_pend = 1'b0;
      s_nxt.tx_act = 1'b0;
      s_nxt.tx_cnt = 8'h00;
      s_nxt.in_len = 8'h00;
      s_nxt.nak = 1'b0;
    end
    s_nxt.irq = s_nxt.flag;
    s_nxt.reg_on = s_nxt.pwr[`USBSH_PWR_REG_EN] && !s_nxt.det_err;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_r <= '0;
      s_r.pwr <= `USBSH_PWR_RST;
      s_r.wait_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign AVS_READDATA = s_r.rdata;
  assign AVS_WAITREQUEST = s_r.wait_n;
  assign TX_NAK = s_r.nak;
  assign TX_ACTIVE = s_r.tx_act;
  assign USB_IRQ = s_r.irq;
  assign USB_REGULATOR_OUTPUT = s_r.reg_on;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  logic ctrl_wr;
  assign ctrl_wr = wr_acc && (AVS_ADDRESS == `USBSH_CTRL_OFS);

  sequence clr_in_hazard;
    clr_req && ep_on && s_r.mod_en && s_r.flag && TOK_IN_CRC2
      && !TOK_SETUP && !ctrl_wr;
  endsequence
  sequence crc_ends;
    s_r.clr_pend && s_r.mod_en && $fell(TOK_IN_CRC2);
  endsequence
  // Guard of five cycles plus the releasing cycle
  sequence guard_drains;
    (!TOK_IN_CRC2 && !clr_req && !TOK_SETUP && !ctrl_wr)[*6];
  endsequence

  setup_sets_a: assert property (
    TOK_SETUP && s_r.mod_en && ep_on && !ctrl_wr |=> USB_IRQ && s_r.flag)
    else $error("setup token did not set pending flag");
  in_nak_a: assert property (
    TOK_IN && s_r.flag && s_r.mod_en && s_r.epi_en && !s_r.tx_act
      && !ctrl_wr |=> TX_NAK && !TX_ACTIVE)
    else $error("IN token not NAKed while flag set");
  hazard_defer_a: assert property (
    clr_in_hazard |=> s_r.flag ##0 s_r.clr_pend)
    else $error("flag cleared inside hazard window");
  hazard_release_a: assert property (
    crc_ends ##0 guard_drains |=> !s_r.flag)
    else $error("deferred clear not applied after window");
  tx_bounded_a: assert property (
    s_r.tx_act && TX_BYTE_SENT && s_r.tx_cnt == 8'h01 |=> !TX_ACTIVE)
    else $error("transmission did not stop at byte count");
  disable_idle_a: assert property (
    ctrl_wr && !AVS_WRITEDATA[0] |=> !TX_ACTIVE && !USB_IRQ && !s_r.clr_pend)
    else $error("module disable did not idle the block");
  pwr_zero_a: assert property (
    wr_acc && AVS_ADDRESS == `USBSH_PWR_OFS && AVS_WRITEDATA[7:0] == 8'h00
      && !s_r.bf_lvl |=> !s_r.det_err && !USB_REGULATOR_OUTPUT)
    else $error("power zero write did not clear error");
  det_set_a: assert property (
    s_r.bf_lvl && s_r.pwr != 8'h00 |=> s_r.det_err && !USB_REGULATOR_OUTPUT)
    else $error("detection fault did not set error");
  hazard_hold_a: assert property (
    s_r.clr_pend && s_r.flag && s_r.guard != 3'h0 && !clr_req && !ctrl_wr
      |=> s_r.flag)
    else $error("deferred clear applied inside guard window");
  bus_answer_a: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered in one cycle");
endmodule

// *** core/usbsh_regs.svh ***
// Register offsets, fields, reset values and timing counts
`ifndef USBSH_REGS_SVH
`define USBSH_REGS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define USBSH_CTRL_OFS 4'h0
`define USBSH_FLAG_OFS 4'h4
`define USBSH_PWR_OFS 4'h8
`define USBSH_INLEN_OFS 4'hC
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USBSH_CTRL_MOD_EN 0
`define USBSH_CTRL_EPI_EN 1
`define USBSH_CTRL_EPO_EN 2
`define USBSH_FLAG_SETUP 0
`define USBSH_FLAG_BUS_POWER_PIN 1
`define USBSH_FLAG_DETERR 2
`define USBSH_FLAG_TXACT 3
`define USBSH_PWR_REG_EN 0
`define USBSH_PWR_DET_EN 1
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define USBSH_PWR_RST 8'h00
`define USBSH_CLK_NS 20
`define USBSH_HAZ_NS 83
`define USBSH_HAZ_CYC ((`USBSH_HAZ_NS + `USBSH_CLK_NS - 1) / `USBSH_CLK_NS)
`endif

// *** core/usbsh_pkg.sv ***
// Types for the setup handshake block
package usbsh_pkg;
  typedef struct packed {
    logic mod_en;
    logic epi_en;
    logic epo_en;
    logic flag;
    logic irq;
    logic clr_pend;
    logic [2:0] guard;
    logic [7:0] pwr;
    logic det_err;
    logic reg_on;
    logic [7:0] in_len;
    logic [7:0] tx_cnt;
    logic tx_act;
    logic nak;
    logic wait_n;
    logic [31:0] rdata;
    logic vs1;
    logic vs2;
    logic vs3;
    logic bus_power_pin_lvl;
    logic bf1;
    logic bf2;
    logic bf3;
    logic bf_lvl;
  } usbsh_state_t;
endpackage

// *** tb/usbsh_host.sv ***
// Host side model: token source and serial byte pacing
`timescale 1ns/1ps
module usbsh_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Device status
  input wire logic tx_active,
  // Token and serial engine strobes
  output logic tok_setup,
  output logic tok_in,
  output logic tok_in_crc2,
  output logic tx_byte_sent
);
  logic [1:0] gap_r = 2'h0;
  initial {tok_setup, tok_in, tok_in_crc2, tx_byte_sent} = 4'h0;
  // One byte every third cycle, none outside a transmission
  always @(posedge clk) begin
    gap_r <= (rst || !tx_active || gap_r == 2'h2) ? 2'h0 : gap_r + 2'h1;
    tx_byte_sent <= tx_active && !rst && gap_r == 2'h2;
  end
  task automatic setup();
    @(posedge clk);
    tok_setup <= 1'b1;
    @(posedge clk);
    tok_setup <= 1'b0;
  endtask
  // Second CRC bit lasts one bit time, token ends two cycles later
  task automatic in_tok();
    @(posedge clk);
    tok_in_crc2 <= 1'b1;
    repeat (4) @(posedge clk);
    tok_in_crc2 <= 1'b0;
    repeat (2) @(posedge clk);
    tok_in <= 1'b1;
    @(posedge clk);
    tok_in <= 1'b0;
  endtask
endmodule

// *** tb/test_usbsh_top.sv ***
// Self-checking bench for the setup handshake block
`timescale 1ns/1ps
`include "usbsh_regs.svh"
module test_usbsh_top;
  localparam logic [3:0] a_ct = `USBSH_CTRL_OFS;
  localparam logic [3:0] a_fl = `USBSH_FLAG_OFS;
  localparam logic [3:0] a_pw = `USBSH_PWR_OFS;
  localparam logic [3:0] a_ln = `USBSH_INLEN_OFS;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, vb = 1'b1, det = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic wait_req, ts, ti, tc, sent, nak, act, irq, reg_out, act_q = 1'b0;
  logic [7:0] tq[$], nb = 8'h00, e, n;
  logic [31:0] rq[$];
  int n_errors = 0, n_checks = 0, k;
  always #10 clk = ~clk;
  usbsh_top u_usbsh_top (.CORE_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req), .TOK_SETUP(ts),
    .TOK_IN(ti), .TOK_IN_CRC2(tc), .TX_BYTE_SENT(sent),
    .BUS_POWER_PIN(vb), .DET_FAULT_PIN(det), .TX_NAK(nak),
    .TX_ACTIVE(act), .USB_IRQ(irq), .USB_REGULATOR_OUTPUT(reg_out));
  usbsh_host u_usbsh_host (.clk(clk), .rst(rst), .tx_active(act),
    .tok_setup(ts), .tok_in(ti), .tok_in_crc2(tc), .tx_byte_sent(sent));
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for a level to drop
  task automatic wait0(ref logic s);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (s !== 1'b0 && i < 200);
    if (i >= 200) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic acc(logic r, logic [3:0] a, logic [31:0] d, logic [31:0] x);
    @(posedge clk);
    rd <= r;
    wr <= !r;
    adr <= a;
    wdat <= d;
    if (r)
      rq.push_back(x);
    wait0(wait_req);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Result watcher: read data, NAK pulses and transmission lengths
  always @(posedge clk) begin
    act_q <= act;
    nb <= act ? nb + 8'(sent) : 8'h00;
    e = 8'hEE;
    if (rd && wait_req === 1'b0 && rq.size() > 0)
      chk("readdata", rdat, rq.pop_front());
    if ((nak === 1'b1 || (act_q && act === 1'b0)) && tq.size() > 0)
      e = tq.pop_front();
    if (nak === 1'b1)
      chk("nak", 8'h00, e);
    if (act_q && act === 1'b0 && e !== 8'hFF)
      chk("tx_bytes", nb, e);
  end
  initial begin
    void'($urandom(94290));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    acc(1, a_pw, 0, 0);
    acc(0, 4'h2, 32'h5, 0);
    acc(1, 4'h2, 0, 0);
    u_usbsh_host.setup();
    acc(1, a_fl, 0, 0);
    acc(0, a_ct, 7, 0);
    for (k = 0; k < 2; k++) begin
      n = 8'h01 + 8'($urandom % 4);
      u_usbsh_host.setup();
      acc(1, a_fl, 0, 1);
      chk("irq", irq, 1'b1);
      tq.push_back(8'h00);
      u_usbsh_host.in_tok();
      acc(0, a_ln, {24'h0, n}, 0);
      if (k == 1)
        tq.push_back(8'h00);
      tq.push_back(n);
      if (k == 0)
        acc(0, a_fl, 1, 0);
      else
        fork
          u_usbsh_host.in_tok();
          acc(0, a_fl, 1, 0);
        join
      repeat (8) @(posedge clk);
      acc(1, a_fl, 0, 0);
      u_usbsh_host.in_tok();
      wait0(act);
    end
    u_usbsh_host.setup();
    acc(0, a_ct, 1, 0);
    fork
      u_usbsh_host.in_tok();
      acc(0, a_fl, 1, 0);
    join
    acc(1, a_fl, 0, 0);
    acc(0, a_ct, 7, 0);
    u_usbsh_host.setup();
    acc(0, a_ln, 32'hFF, 0);
    acc(0, a_fl, 1, 0);
    tq.push_back(8'hFF);
    u_usbsh_host.in_tok();
    u_usbsh_host.setup();
    acc(0, a_ct, 0, 0);
    @(posedge clk);
    chk("active", act, 1'b0);
    chk("irq", irq, 1'b0);
    acc(0, a_ct, 7, 0);
    acc(1, a_fl, 0, 0);
    acc(1, a_ln, 0, 0);
    acc(0, a_pw, 3, 0);
    repeat (8) @(posedge clk);
    acc(1, a_fl, 0, 2);
    chk("regulator", reg_out, 1'b1);
    det <= 1'b1;
    repeat (8) @(posedge clk);
    det <= 1'b0;
    repeat (8) @(posedge clk);
    acc(1, a_fl, 0, 4);
    chk("regulator", reg_out, 1'b0);
    acc(0, a_pw, 0, 0);
    acc(1, a_fl, 0, 0);
    acc(0, a_pw, 3, 0);
    acc(1, a_fl, 0, 2);
    chk("regulator", reg_out, 1'b1);
    vb <= 1'b0;
    repeat (8) @(posedge clk);
    acc(1, a_fl, 0, 0);
    chk("pending", tq.size(), 0);
    wrap_up();
  end
endmodule
